// ==== rtl/usbsr_core.v ====
`timescale 1ns/1ps
`default_nettype none
`include "usbsr_defs.vh"

// What this block does
// RULE1 - K 20ms, wake high, or CS low resume
// RULE2 - local wake drives K for 10ms
// RULE3 - CS wake needs enable bit and VBUS
// RULE4 - restart oscillator, route clocks once stable
// RULE5 - wake drops suspend, sets resume flag, irq
// RULE6 - normal operation within 15ms of wake
// RULE7 - writes blocked after any wake-up
// RULE8 - code AA37 releases the write lock
// RULE9 - suspend on falling suspend command bit
// RULE10 - firmware sets then clears suspend command
// RULE11 - awake-to-suspend sets flag, optional irq
// RULE12 - live bit shows bus suspended
// RULE13 - connect bit switches bus pull-up
// RULE14 - config bit picks internal or external pull-up
// RULE15 - powered-off mode holds suspend output
// RULE16 - application restores itself after suspend drops
// RULE17 - bus idle over 3ms means suspend
// RULE18 - powered-off: suspend, clocks off after 2ms
// RULE19 - firmware clears clock run before suspend
// RULE20 - locked writes are ignored
// RULE21 - clock restart precedes remote wake K
module usbsr_core #(
   parameter [17:0] IDLE_CYC   = (`USBSR_T_IDLE_US * 1000 +
                                  `USBSR_CLK_PERIOD_NS - 1) /
                                 `USBSR_CLK_PERIOD_NS,
   parameter [17:0] RES_K_CYC  = (`USBSR_T_RESUME_K_US * 1000 +
                                  `USBSR_CLK_PERIOD_NS - 1) /
                                 `USBSR_CLK_PERIOD_NS,
   parameter [17:0] REM_K_CYC  = (`USBSR_T_REMOTE_K_US * 1000 +
                                  `USBSR_CLK_PERIOD_NS - 1) /
                                 `USBSR_CLK_PERIOD_NS,
   parameter [17:0] POWERED_OFF_MODE_SELECT_CYC = (`USBSR_T_POWERED_OFF_MODE_SELECT_US * 1000 +
                                  `USBSR_CLK_PERIOD_NS - 1) /
                                 `USBSR_CLK_PERIOD_NS,
   parameter [17:0] SETTLE_CYC = `USBSR_OSC_SETTLE_CYC
) (
   input  wire        clock_i,         // 10 MHz system clock
   input  wire        rst_i,           // sync reset, active high
   input  wire        line_idle_i,     // bus in idle (J) state, pin
   input  wire        line_k_i,        // bus in K state, pin
   input  wire        wake_i,          // local wake pin, high wakes
   input  wire        cs_n_i,          // chip select pin, active low
   input  wire        vbus_i,          // bus power present, pin
   input  wire        mode_wr_i,       // write strobe, mode register
   input  wire [1:0]  mode_data_i,     // mode register data
   input  wire        hwcfg_wr_i,      // write strobe, hw config
   input  wire [3:0]  hwcfg_data_i,    // hw config data
   input  wire        irqen_wr_i,      // write strobe, irq enables
   input  wire [1:0]  irqen_data_i,    // irq enable data
   input  wire        unlock_wr_i,     // write strobe, lock release
   input  wire [15:0] unlock_data_i,   // lock release data
   input  wire [1:0]  flag_clr_i,      // pulse, clear irq flags
   output reg         suspend_o,       // suspend indication pin
   output reg         osc_en_o,        // oscillator and pll enable
   output reg         clk_route_o,     // clocks routed to logic
   output reg         active_o,        // normal operation
   output reg         k_drive_o,       // drive K state on bus
   output reg         int_pullup_o,    // internal pull-up on
   output reg         ext_pullup_o,    // external pull-up on
   output reg         irq_o,           // interrupt request
   output reg  [1:0]  irq_flags_o,     // {resume, suspend} flags
   output reg         bus_idle_state_o,// live bus suspended bit
   output reg         wr_locked_o,     // register writes locked
   output reg  [1:0]  mode_o,          // mode register readback
   output reg  [3:0]  hwcfg_o,         // hw config readback
   output reg  [1:0]  irqen_o          // irq enable readback
);

   localparam [4:0] ST_AWAKE = 5'h01;
   localparam [4:0] ST_SUSP  = 5'h02;
   localparam [4:0] ST_CLK   = 5'h04;
   localparam [4:0] ST_WAKEK = 5'h08;
   localparam [4:0] ST_SPARE = 5'h10;

   reg  [4:0]  pin_meta_q;
   reg  [4:0]  pin_q;
   reg  [4:0]  state_q;
   reg  [4:0]  state_d;
   reg         remote_q;
   reg  [17:0] phase_lim;
   wire        idle_done;
   wire        k_done;
   wire        phase_done;
   wire        cs_wake;
   wire        local_wake;
   wire        host_wake;
   wire        unlock_hit;
   wire        susp_cmd_fall;
   wire        wr_ok;

   // pins sampled twice before use
   always @(posedge clock_i) begin
      if (rst_i) begin
         pin_meta_q <= `USBSR_PIN_RST;
         pin_q      <= `USBSR_PIN_RST;
      end else begin
         pin_meta_q <= {vbus_i, cs_n_i, wake_i, line_k_i, line_idle_i};
         pin_q      <= pin_meta_q;
      end
   end

   usbsr_timer #(.W(18)) u_idle (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .run_i   (pin_q[`USBSR_PIN_IDLE]),
      .limit_i (IDLE_CYC + 18'h00001),   // RULE17
      .done_o  (idle_done)
   );

   usbsr_timer #(.W(18)) u_kres (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .run_i   (pin_q[`USBSR_PIN_K] && state_q == ST_SUSP),
      .limit_i (RES_K_CYC),
      .done_o  (k_done)
   );

   // phase timer restarts on every state change
   usbsr_timer #(.W(18)) u_phase (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .run_i   (state_d == state_q),
      .limit_i (phase_lim),
      .done_o  (phase_done)
   );

   always @* begin
      if (state_q == ST_SUSP) begin
         phase_lim = POWERED_OFF_MODE_SELECT_CYC;
      end else if (state_q == ST_WAKEK) begin
         phase_lim = REM_K_CYC;
      end else begin
         phase_lim = SETTLE_CYC;
      end
   end

   assign cs_wake    = !pin_q[`USBSR_PIN_CS_N] &&
                       hwcfg_o[`USBSR_HW_CS_WAKE] &&
                       pin_q[`USBSR_PIN_VBUS];            // RULE3
   assign local_wake = pin_q[`USBSR_PIN_WAKE] || cs_wake;  // RULE1
   assign host_wake  = k_done;                             // RULE1
   assign unlock_hit = unlock_wr_i &&
                       unlock_data_i == `USBSR_UNLOCK_CODE; // RULE8
   assign wr_ok      = !wr_locked_o;                       // RULE20
   assign susp_cmd_fall = wr_ok && mode_wr_i &&
                          mode_o[`USBSR_MODE_SUSP_CMD] &&
                          !mode_data_i[`USBSR_MODE_SUSP_CMD]; // RULE9

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_AWAKE: begin
            if (susp_cmd_fall) begin
               state_d = ST_SUSP;                          // RULE9
            end
         end
         ST_SUSP: begin
            if (host_wake || local_wake) begin
               state_d = ST_CLK;                           // RULE4
            end
         end
         ST_CLK: begin
            // remote K only once clocks are stable
            if (phase_done) begin
               state_d = remote_q ? ST_WAKEK : ST_AWAKE;   // RULE21
            end
         end
         ST_WAKEK: begin
            if (phase_done) begin
               state_d = ST_AWAKE;                         // RULE2
            end
         end
         default: begin
            state_d = ST_AWAKE;
         end
      endcase
   end

   always @(posedge clock_i) begin
      if (rst_i) begin
         state_q  <= ST_AWAKE;
         remote_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (state_q == ST_SUSP && state_d == ST_CLK) begin
            remote_q <= !host_wake;                        // RULE2
         end
      end
   end

   // registers, flags and lock
   always @(posedge clock_i) begin
      if (rst_i) begin
         mode_o           <= `USBSR_MODE_RST;
         hwcfg_o          <= `USBSR_HW_RST;
         irqen_o          <= `USBSR_IRQEN_RST;
         wr_locked_o      <= 1'b0;
         irq_flags_o      <= 2'h0;
         bus_idle_state_o <= 1'b0;
      end else begin
         if (wr_ok && mode_wr_i) begin
            mode_o <= mode_data_i;                         // RULE20
         end
         if (wr_ok && hwcfg_wr_i) begin
            hwcfg_o <= hwcfg_data_i;                       // RULE20
         end
         if (wr_ok && irqen_wr_i) begin
            irqen_o <= irqen_data_i;                       // RULE20
         end
         // a fresh wake beats a same-cycle unlock
         if (state_q == ST_CLK && phase_done) begin
            wr_locked_o <= 1'b1;                           // RULE7
         end else if (unlock_hit) begin
            wr_locked_o <= 1'b0;                           // RULE8
         end
         bus_idle_state_o <= idle_done;                    // RULE12
         // set wins over clear
         irq_flags_o[`USBSR_IRQ_SUSP] <=
            (idle_done && !bus_idle_state_o) ||
            (irq_flags_o[`USBSR_IRQ_SUSP] &&
             !flag_clr_i[`USBSR_IRQ_SUSP]);                // RULE11
         irq_flags_o[`USBSR_IRQ_RESM] <=
            (state_q == ST_CLK && phase_done) ||
            (irq_flags_o[`USBSR_IRQ_RESM] &&
             !flag_clr_i[`USBSR_IRQ_RESM]);                // RULE5
      end
   end

   // outputs from flip-flops, one cycle behind their causes
   always @(posedge clock_i) begin
      if (rst_i) begin
         suspend_o    <= 1'b0;
         osc_en_o     <= 1'b1;
         clk_route_o  <= 1'b1;
         active_o     <= 1'b1;
         k_drive_o    <= 1'b0;
         int_pullup_o <= 1'b0;
         ext_pullup_o <= 1'b0;
         irq_o        <= 1'b0;
      end else begin
         if (state_d == ST_SUSP) begin
            // powered-off: suspend waits 2ms; clock stops with it, or at once if clock run is clear
            if (hwcfg_o[`USBSR_HW_POWERED_OFF_MODE_SELECT]) begin
               suspend_o <= phase_done && state_q == ST_SUSP; // RULE18
               osc_en_o  <= !(phase_done && state_q == ST_SUSP) &&
                            hwcfg_o[`USBSR_HW_CLK_RUN];    // RULE18
            end else begin
               suspend_o <= 1'b1;                          // RULE15
               osc_en_o  <= hwcfg_o[`USBSR_HW_CLK_RUN];
            end
            clk_route_o <= 1'b0;
            active_o    <= 1'b0;
         end else if (state_d == ST_CLK) begin
            // powered-off keeps suspend until clocks are stable
            osc_en_o    <= 1'b1;                           // RULE4
            clk_route_o <= 1'b0;                           // RULE4
            active_o    <= 1'b0;
         end else begin
            suspend_o   <= 1'b0;                           // RULE5
            osc_en_o    <= 1'b1;
            clk_route_o <= 1'b1;                           // RULE4
            active_o    <= 1'b1;                           // RULE6
         end
         k_drive_o    <= (state_d == ST_WAKEK);            // RULE2
         int_pullup_o <= mode_o[`USBSR_MODE_PULLUP] &&
                         !hwcfg_o[`USBSR_HW_EXT_PULLUP];   // RULE13
         ext_pullup_o <= mode_o[`USBSR_MODE_PULLUP] &&
                         hwcfg_o[`USBSR_HW_EXT_PULLUP];    // RULE14
         irq_o <= (irq_flags_o[`USBSR_IRQ_SUSP] &&
                   irqen_o[`USBSR_IRQ_SUSP]) ||
                  (irq_flags_o[`USBSR_IRQ_RESM] &&
                   irqen_o[`USBSR_IRQ_RESM]);              // RULE11
      end
   end

endmodule // usbsr_core

`default_nettype wire

// ==== rtl/usbsr_defs.vh ====
`ifndef USBSR_DEFS_VH
`define USBSR_DEFS_VH

// clock
`define USBSR_CLK_PERIOD_NS   100

// times in microseconds
`define USBSR_T_IDLE_US       3000
`define USBSR_T_RESUME_K_US   20000
`define USBSR_T_REMOTE_K_US   10000
`define USBSR_T_POWERED_OFF_MODE_SELECT_US     2000
`define USBSR_T_WAKE_MAX_US   15000

// oscillator and pll settle time, well inside the wake limit
`define USBSR_OSC_SETTLE_CYC  1000

// write lock release code
`define USBSR_UNLOCK_CODE     16'hAA37

// dev_mode_register fields
`define USBSR_MODE_PULLUP     0
`define USBSR_MODE_SUSP_CMD   1
`define USBSR_MODE_RST        2'h0

// dev_hw_config_register fields
`define USBSR_HW_EXT_PULLUP   0
`define USBSR_HW_CS_WAKE      1
`define USBSR_HW_POWERED_OFF_MODE_SELECT       2
`define USBSR_HW_CLK_RUN      3
`define USBSR_HW_RST          4'h8

// dev_irq_enable_register and dev_irq_register flag fields
`define USBSR_IRQ_SUSP        0
`define USBSR_IRQ_RESM        1
`define USBSR_IRQEN_RST       2'h0

// synchronised pin vector {vbus, cs_n, wake, k, idle}
`define USBSR_PIN_IDLE        0
`define USBSR_PIN_K           1
`define USBSR_PIN_WAKE        2
`define USBSR_PIN_CS_N        3
`define USBSR_PIN_VBUS        4
`define USBSR_PIN_RST         5'h08

`endif

// ==== rtl/usbsr_timer.v ====
`timescale 1ns/1ps
`default_nettype none

// counts cycles while run_i is high, clears when low, saturates
module usbsr_timer #(
   parameter W = 18
) (
   input  wire         clock_i,  // system clock
   input  wire         rst_i,    // sync reset, active high
   input  wire         run_i,    // count while high
   input  wire [W-1:0] limit_i,  // cycles to reach done
   output wire         done_o    // count has reached limit
);

   reg [W-1:0] cnt_q;

   assign done_o = (cnt_q >= limit_i);

   always @(posedge clock_i) begin
      if (rst_i || !run_i) begin
         cnt_q <= {W{1'b0}};
      end else if (!done_o) begin
         cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      end
   end

endmodule // usbsr_timer

`default_nettype wire

// ==== sim/usbsr_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// far-side port: 0 traffic, 1 idle J, 2 resume K
module usbsr_host_model (
   input  wire logic [1:0] host_st_i,   // bus state command
   output wire logic       line_idle_o, // idle level
   output wire logic       line_k_o     // K level
);
   assign line_idle_o = host_st_i == 2'h1;
   assign line_k_o    = host_st_i == 2'h2;
endmodule // usbsr_host_model
`default_nettype wire

// ==== sim/usbsr_core_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module usbsr_core_properties (
   input wire logic       clock_i, rst_i, mode_wr_i, hwcfg_wr_i,
   input wire logic       irqen_wr_i, unlock_wr_i, suspend_o, osc_en_o,
   input wire logic       clk_route_o, active_o, k_drive_o, irq_o,
   input wire logic       int_pullup_o, ext_pullup_o, bus_idle_state_o,
   input wire logic       wr_locked_o,
   input wire logic [1:0] mode_data_i, mode_o, irq_flags_o, irqen_o,
   input wire logic [3:0] hwcfg_o,
   input wire logic [15:0] unlock_data_i
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   sequence s_go;
      active_o && !k_drive_o && !wr_locked_o && mode_wr_i &&
      mode_o[1] && !mode_data_i[1];
   endsequence
   property p_wake; $rose(active_o) |->
      wr_locked_o && irq_flags_o[1] && !suspend_o; endproperty
   a_wake: assert property (p_wake) else $error("wake state");
   property p_unlock; unlock_wr_i && unlock_data_i == 16'hAA37 && active_o
      |=> !wr_locked_o; endproperty
   a_unlock: assert property (p_unlock) else $error("unlock");
   property p_ignore; wr_locked_o && (mode_wr_i || hwcfg_wr_i ||
      irqen_wr_i) |=> $stable({mode_o, hwcfg_o, irqen_o}); endproperty
   a_ignore: assert property (p_ignore) else $error("locked write");
   property p_enter; s_go |=> !active_o && !clk_route_o &&
      suspend_o == !hwcfg_o[2]; endproperty
   a_enter: assert property (p_enter) else $error("enter");
   // powered-off: pin stays low during the clock-off delay
   property p_powered_off_mode_select; s_go ##0 hwcfg_o[2] |=>
      !suspend_o [*8] ##1 !suspend_o [*3] ##1 suspend_o; endproperty
   a_powered_off_mode_select: assert property (p_powered_off_mode_select) else $error("powered_off_mode_select");
   property p_klen; $rose(k_drive_o) |-> active_o && clk_route_o &&
      k_drive_o [*8] ##1 k_drive_o [*8] ##1 !k_drive_o; endproperty
   a_klen: assert property (p_klen) else $error("remote k");
   property p_settle; $rose(clk_route_o) |->
      osc_en_o && $past(osc_en_o, 3); endproperty
   a_settle: assert property (p_settle) else $error("settle");
   property p_sflag; $rose(bus_idle_state_o) |-> irq_flags_o[0];
   endproperty
   a_sflag: assert property (p_sflag) else $error("susp flag");
   property p_irq; (irq_flags_o & irqen_o) != 2'h0 |=> irq_o; endproperty
   a_irq: assert property (p_irq) else $error("irq");
   property p_pull; mode_o[0] && !hwcfg_o[0] |=>
      int_pullup_o && !ext_pullup_o; endproperty
   a_pull: assert property (p_pull) else $error("pullup");
   c_go: cover property (s_go);
   c_k: cover property ($rose(k_drive_o));
   c_idle: cover property ($rose(bus_idle_state_o));
endmodule // usbsr_core_properties
bind usbsr_core usbsr_core_properties u_props (.*);
`default_nettype wire

// ==== sim/usbsr_core_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module usbsr_core_tb_top;
   localparam M = 8, H = 4, I = 2, U = 1;
   logic clock_i = 0, rst_i = 1, wake_i = 0, cs_n_i = 1, vbus_i = 1;
   logic mode_wr_i = 0, hwcfg_wr_i = 0, irqen_wr_i = 0, unlock_wr_i = 0;
   logic [1:0] mode_data_i = 0, irqen_data_i = 0, flag_clr_i = 0;
   logic [1:0] host_st = 0;
   logic [3:0] hwcfg_data_i = 0;
   logic [15:0] unlock_data_i = 0;
   wire suspend_o, osc_en_o, clk_route_o, active_o, k_drive_o, irq_o;
   wire int_pullup_o, ext_pullup_o, bus_idle_state_o, wr_locked_o;
   wire line_idle_i, line_k_i;
   wire [1:0] irq_flags_o, mode_o, irqen_o;
   wire [3:0] hwcfg_o;
   wire [3:0] ev = {k_drive_o, active_o, bus_idle_state_o, suspend_o};
   int num_errors = 0, n_tests = 0, cnt;
   usbsr_core #(.IDLE_CYC(20), .RES_K_CYC(30), .REM_K_CYC(15),
      .POWERED_OFF_MODE_SELECT_CYC(10), .SETTLE_CYC(5)) DUT (.*);
   usbsr_host_model HOST (
      .host_st_i   (host_st),
      .line_idle_o (line_idle_i),
      .line_k_o    (line_k_i)
   );
   always #50 clock_i = ~clock_i;
   task finish_test;
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input string n, input [15:0] e, input [15:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask
   task wr(input [3:0] r, input [15:0] d);
      @(negedge clock_i);
      {mode_wr_i, hwcfg_wr_i, irqen_wr_i, unlock_wr_i} = r;
      mode_data_i = d[1:0];
      hwcfg_data_i = d[3:0];
      irqen_data_i = d[1:0];
      unlock_data_i = d;
      @(negedge clock_i);
      {mode_wr_i, hwcfg_wr_i, irqen_wr_i, unlock_wr_i} = 4'h0;
   endtask
   // bounded wait on one event bit
   task wt(input int b, input logic v);
      for (cnt = 0; cnt < 500 && ev[b] !== v; cnt++) @(negedge clock_i);
      if (cnt >= 500) begin
         num_errors++;
         $display("unexpected wait on bit %0d exp %0d got timeout", b, v);
      end
   endtask
   task sus;
      wr(M, 16'h0003);
      wr(M, 16'h0001);
   endtask
   initial begin
      #300000;
      num_errors++;
      finish_test;
   end
   initial begin
      repeat (6) @(negedge clock_i);
      rst_i = 0;
      wr(H, 16'h000A);
      chk("hwcfg", 16'h000A, hwcfg_o);
      wr(I, 16'h0003);
      chk("irqen", 16'h0003, irqen_o);
      wr(M, 16'h0001);
      @(negedge clock_i);
      chk("pullup", 16'h0001, int_pullup_o);
      chk("ext pullup", 16'h0000, ext_pullup_o);
      wr(H, 16'h000B);
      @(negedge clock_i);
      chk("ext sel int", 16'h0000, int_pullup_o);
      chk("ext sel ext", 16'h0001, ext_pullup_o);
      wr(H, 16'h000A);
      host_st = 2'h1;
      wt(1, 1);
      chk("idle time", 16'h0001, cnt >= 20);
      chk("idle bit", 16'h0001, bus_idle_state_o);
      chk("susp flag", 16'h0001, irq_flags_o[0]);
      @(negedge clock_i);
      chk("irq", 16'h0001, irq_o);
      flag_clr_i = 2'h3;
      @(negedge clock_i);
      flag_clr_i = 2'h0;
      sus;
      chk("susp pin", 16'h0001, suspend_o);
      chk("active", 16'h0000, active_o);
      chk("route", 16'h0000, clk_route_o);
      cs_n_i = 0;
      wt(2, 1);
      cs_n_i = 1;
      chk("wake time", 16'h0001, cnt >= 5 && cnt < 150000);
      chk("resume flag", 16'h0001, irq_flags_o[1]);
      chk("susp drop", 16'h0000, suspend_o);
      chk("locked", 16'h0001, wr_locked_o);
      wt(3, 1);
      wt(3, 0);
      chk("k len", 16'd16, cnt);
      chk("resume irq", 16'h0001, irq_o);
      wr(M, 16'h0000);
      chk("mode kept", 16'h0001, mode_o);
      wr(U, 16'hAA36);
      chk("bad code", 16'h0001, wr_locked_o);
      wr(U, 16'hAA37);
      chk("unlock", 16'h0000, wr_locked_o);
      wr(H, 16'h0008);
      sus;
      cs_n_i = 0;
      repeat (30) @(negedge clock_i);
      chk("cs gated", 16'h0000, active_o);
      wake_i = 1;
      wt(2, 1);
      wake_i = 0;
      cs_n_i = 1;
      chk("wake pin", 16'h0001, active_o);
      wt(3, 1);
      chk("remote k", 16'h0001, k_drive_o);
      wt(3, 0);
      wt(0, 0);
      wr(U, 16'hAA37);
      wr(H, 16'h0000);
      sus;
      chk("clk stop", 16'h0000, osc_en_o);
      host_st = 2'h2;
      wt(2, 1);
      chk("k resume time", 16'h0001, cnt >= 30);
      chk("idle bit low", 16'h0000, bus_idle_state_o);
      repeat (4) @(negedge clock_i);
      chk("no remote k", 16'h0000, k_drive_o);
      host_st = 2'h1;
      wr(U, 16'hAA37);
      wr(H, 16'h000C);
      sus;
      chk("powered_off_mode_select pin", 16'h0000, suspend_o);
      wt(0, 1);
      chk("powered_off_mode_select delay", 16'h0001, cnt >= 8);
      repeat (2) @(negedge clock_i);
      chk("osc off", 16'h0000, osc_en_o);
      chk("held", 16'h0001, suspend_o);
      wake_i = 1;
      wt(2, 1);
      wake_i = 0;
      chk("powered_off_mode_select wake", 16'h0000, suspend_o);
      finish_test;
   end
endmodule // usbsr_core_tb_top
`default_nettype wire
